// ==== hw/cmp_defs.svh ====
// Register offsets, field positions, reset values and widths of the comparator control
`ifndef CMP_DEFS_SVH
`define CMP_DEFS_SVH

`define CMP_ADDR_W        12
`define CMP_OFF_CONFIG    12'h000
`define CMP_OFF_AUX       12'h004
`define CMP_OFF_STATUS    12'h008
`define CMP_OFF_CLEAR     12'h00C
`define CMP_OFF_ENABLE    12'h010
`define CMP_OFF_GATES     12'h014

`define CMP_CFG_RESULT    6
`define CMP_CFG_INVERT    4
`define CMP_CFG_SWITCH    3
`define CMP_CFG_MODE_HI   2

`define CMP_IRQ_CHANGE    0
`define CMP_IRQ_WAKE      1
`define CMP_GATE_PERIPH   0
`define CMP_GATE_GLOBAL   1

`define CMP_CFG_RESET     8'h00
`define CMP_AUX_RESET     2'h0
`define CMP_MODE_OFF_LO   3'h0
`define CMP_MODE_OFF_HI   3'h7
`define CMP_ZERO32        32'h0000_0000

`endif

// ==== hw/cmp_pkg.sv ====
// Types and mode decoding shared by the comparator control modules
`include "cmp_defs.svh"
package cmp_pkg;

    typedef struct packed {
        logic       invert;
        logic       in_switch;
        logic [2:0] mode;
    } cfg_t;

    typedef enum logic [1:0] {
        W_AWAKE,
        W_ASLEEP,
        W_STEP
    } wake_state_t;

    function automatic logic mode_is_on(input logic [2:0] m);
        return (m != `CMP_MODE_OFF_LO) && (m != `CMP_MODE_OFF_HI);
    endfunction

    function automatic logic mode_drives_pin(input logic [2:0] m);
        return (m == 3'h1) || (m == 3'h3) || (m == 3'h5);
    endfunction

    // Bit 1: inverting input analog, bit 0: non-inverting input analog
    function automatic logic [1:0] mode_analog_pins(input logic [2:0] m);
        unique case (m)
            3'h3, 3'h4: return 2'h2;
            3'h7:       return 2'h0;
            default:    return 2'h3;
        endcase
    endfunction

endpackage

// ==== hw/cmp_mismatch.sv ====
// Reference latch and sampling latch that detect a change of the comparator output
`timescale 1ns/100ps
module cmp_mismatch (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic result,
    input  wire logic capture,
    output logic      sample,
    output logic      mismatch
);
    typedef struct packed {
        logic ref_val;
        logic sample;
    } mm_state_t;

    mm_state_t st_r;
    mm_state_t st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.sample = result;
        // Register access takes the latched level, so the mismatch ends next cycle
        if (capture) begin
            st_nxt.ref_val = st_r.sample;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign sample   = st_r.sample;
    assign mismatch = st_r.sample ^ st_r.ref_val;
endmodule

// ==== hw/cmp_wake.sv ====
// Sleep tracking, wake request and deferred interrupt branch towards the core
`timescale 1ns/100ps
module cmp_wake (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic core_sleep,
    input  wire logic wake_cond,
    input  wire logic global_irq_gate,
    input  wire logic instr_done,
    output logic      wake_req,
    output logic      isr_req,
    output logic      wake_event
);
    typedef struct packed {
        cmp_pkg::wake_state_t state;
        logic                 wake;
        logic                 isr;
        logic                 event_p;
    } wk_state_t;

    wk_state_t st_r;
    wk_state_t st_nxt;

    always_comb begin
        st_nxt         = st_r;
        st_nxt.isr     = 1'b0;
        st_nxt.event_p = 1'b0;
        unique case (st_r.state)
            cmp_pkg::W_AWAKE: begin
                if (core_sleep) begin
                    st_nxt.state = cmp_pkg::W_ASLEEP;
                end
            end
            cmp_pkg::W_ASLEEP: begin
                if (wake_cond) begin
                    st_nxt.state   = cmp_pkg::W_STEP;
                    st_nxt.wake    = 1'b1;
                    st_nxt.event_p = 1'b1;
                end else if (!core_sleep) begin
                    st_nxt.state = cmp_pkg::W_AWAKE;
                end
            end
            cmp_pkg::W_STEP: begin
                if (!core_sleep) begin
                    st_nxt.wake = 1'b0;
                end
                // Branch only once the instruction after sleep has retired
                if (instr_done && !core_sleep) begin
                    st_nxt.state = cmp_pkg::W_AWAKE;
                    st_nxt.isr   = global_irq_gate;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{state: cmp_pkg::W_AWAKE, wake: 1'b0, isr: 1'b0, event_p: 1'b0};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign wake_req   = st_r.wake;
    assign isr_req    = st_r.isr;
    assign wake_event = st_r.event_p;
endmodule

// ==== hw/cmp_ctrl.sv ====
// Comparator control: APB registers, change flag, interrupts, pin modes and sleep wake
`timescale 1ns/100ps
`include "cmp_defs.svh"
module cmp_ctrl #(
    parameter int ADDR_W = `CMP_ADDR_W,
    parameter int AUX_W  = 2
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              cmp_raw,
    input  wire logic              core_sleep,
    input  wire logic              instr_done,
    output logic                   comparator_on,
    output logic      [1:0]        analog_pin_en,
    output logic                   input_switch,
    output logic                   result_pin_out,
    output logic                   result_pin_en,
    output logic      [AUX_W-1:0]  aux_ctrl,
    output logic                   irq,
    output logic                   wake_req,
    output logic                   isr_req
);

    typedef struct packed {
        cmp_pkg::cfg_t    cfg;
        logic [AUX_W-1:0] aux;
        logic [1:0]       status;
        logic [1:0]       enable;
        logic [1:0]       gates;
        logic             pin_en;
        logic [1:0]       pins;
        logic             on;
        logic [31:0]      rdata;
    } ctrl_state_t;

    ctrl_state_t st_r;
    ctrl_state_t st_nxt;

    logic              setup;
    logic              access;
    logic              wr_acc;
    logic              rd_acc;
    logic              hit;
    logic [ADDR_W-1:0] off;
    logic              result;
    logic              result_q;
    logic              mismatch;
    logic              capture;
    logic              wake_cond;
    logic              wake_event;
    logic [1:0]        clr_bits;
    logic [1:0]        set_bits;
    logic [7:0]        cfg_view;

    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign wr_acc = access && pwrite;
    assign rd_acc = access && !pwrite;
    assign off    = paddr;

    always_comb begin
        unique case (off)
            `CMP_OFF_CONFIG,
            `CMP_OFF_AUX,
            `CMP_OFF_STATUS,
            `CMP_OFF_CLEAR,
            `CMP_OFF_ENABLE,
            `CMP_OFF_GATES: hit = 1'b1;
            default:        hit = 1'b0;
        endcase
    end

    // Off comparator reads 0 before inversion, so invert alone shows a 1
    assign result = (cmp_pkg::mode_is_on(st_r.cfg.mode) & cmp_raw)
                    ^ st_r.cfg.invert;

    // A write counts as a read of the configuration, ending any mismatch
    assign capture = access && hit && (off == `CMP_OFF_CONFIG);

    cmp_mismatch u_mismatch (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .result   (result),
        .capture  (capture),
        .sample   (result_q),
        .mismatch (mismatch)
    );

    assign wake_cond = st_r.status[`CMP_IRQ_CHANGE]
                       && st_r.enable[`CMP_IRQ_CHANGE]
                       && st_r.gates[`CMP_GATE_PERIPH];

    cmp_wake u_wake (
        .pclk            (pclk),
        .presetn         (presetn),
        .ce              (ce),
        .core_sleep      (core_sleep),
        .wake_cond       (wake_cond),
        .global_irq_gate (st_r.gates[`CMP_GATE_GLOBAL]),
        .instr_done      (instr_done),
        .wake_req        (wake_req),
        .isr_req         (isr_req),
        .wake_event      (wake_event)
    );

    always_comb begin
        cfg_view                  = 8'h00;
        cfg_view[`CMP_CFG_RESULT] = result_q;
        cfg_view[`CMP_CFG_INVERT] = st_r.cfg.invert;
        cfg_view[`CMP_CFG_SWITCH] = st_r.cfg.in_switch;
        cfg_view[`CMP_CFG_MODE_HI:0] = st_r.cfg.mode;
    end

    always_comb begin
        clr_bits = 2'h0;
        if (wr_acc && (off == `CMP_OFF_CLEAR)) begin
            clr_bits = pwdata[1:0];
        end
    end

    always_comb begin
        set_bits                 = 2'h0;
        // Level set: a standing mismatch keeps the flag from being cleared
        set_bits[`CMP_IRQ_CHANGE] = mismatch;
        set_bits[`CMP_IRQ_WAKE]   = wake_event;
    end

    always_comb begin
        st_nxt     = st_r;

        // Read data is prepared in the setup phase so it comes from a register
        if (setup) begin
            st_nxt.rdata = `CMP_ZERO32;
            unique case (off)
                `CMP_OFF_CONFIG: begin
                    st_nxt.rdata[7:0] = cfg_view;
                end
                `CMP_OFF_AUX: begin
                    st_nxt.rdata[AUX_W-1:0] = st_r.aux;
                end
                `CMP_OFF_STATUS: begin
                    st_nxt.rdata[1:0] = st_r.status;
                end
                `CMP_OFF_ENABLE: begin
                    st_nxt.rdata[1:0] = st_r.enable;
                end
                `CMP_OFF_GATES: begin
                    st_nxt.rdata[1:0] = st_r.gates;
                end
                default: begin
                    st_nxt.rdata = `CMP_ZERO32;
                end
            endcase
        end

        if (wr_acc && hit) begin
            unique case (off)
                `CMP_OFF_CONFIG: begin
                    st_nxt.cfg.invert    = pwdata[`CMP_CFG_INVERT];
                    st_nxt.cfg.in_switch = pwdata[`CMP_CFG_SWITCH];
                    st_nxt.cfg.mode      = pwdata[`CMP_CFG_MODE_HI:0];
                end
                `CMP_OFF_AUX: begin
                    st_nxt.aux = pwdata[AUX_W-1:0];
                end
                `CMP_OFF_ENABLE: begin
                    st_nxt.enable = pwdata[1:0];
                end
                `CMP_OFF_GATES: begin
                    st_nxt.gates = pwdata[1:0];
                end
                default: begin
                    st_nxt.aux = st_r.aux;
                end
            endcase
        end

        // Set wins over a clear arriving in the same cycle
        st_nxt.status = (st_r.status & ~clr_bits) | set_bits;

        st_nxt.on     = cmp_pkg::mode_is_on(st_nxt.cfg.mode);
        st_nxt.pins   = cmp_pkg::mode_analog_pins(st_nxt.cfg.mode);
        st_nxt.pin_en = cmp_pkg::mode_drives_pin(st_nxt.cfg.mode);
    end

    // Reset state: mode 000, comparator off, both inputs analog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r          <= '0;
            st_r.cfg      <= cmp_pkg::cfg_t'(5'(`CMP_CFG_RESET));
            st_r.aux      <= `CMP_AUX_RESET;
            st_r.pins     <= 2'h3;
            st_r.on       <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign prdata  = st_r.rdata;
    // Zero wait states; an unmapped offset answers with an error
    assign pready  = 1'b1;
    assign pslverr = access && !hit;

    assign comparator_on  = st_r.on;
    assign analog_pin_en  = st_r.pins;
    assign input_switch   = st_r.cfg.in_switch;
    assign result_pin_out = result_q;
    assign result_pin_en  = st_r.pin_en;
    assign aux_ctrl       = st_r.aux;
    assign irq            = |(st_r.status & st_r.enable);

endmodule

// ==== bench/cmp_ctrl_properties.sv ====
// Port-level assertions for the comparator control block
`timescale 1ns/100ps
module cmp_ctrl_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cmp_raw,
    input wire logic        core_sleep,
    input wire logic        instr_done,
    input wire logic        comparator_on,
    input wire logic [1:0]  analog_pin_en,
    input wire logic        input_switch,
    input wire logic        result_pin_out,
    input wire logic        result_pin_en,
    input wire logic [1:0]  aux_ctrl,
    input wire logic        irq,
    input wire logic        wake_req,
    input wire logic        isr_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       wr_cfg;
    logic [2:0] wm_r;
    // A write with the clock enable low is dropped by the block
    assign wr_cfg = ce && psel && penable && pwrite && paddr == 12'h000;
    // Mode of the last config write, for the derived pin checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wm_r <= 3'h0;
        else if (wr_cfg) wm_r <= pwdata[2:0];
    end
    property p_on; wr_cfg |-> ##2 comparator_on == (wm_r != 3'h0 && wm_r != 3'h7); endproperty
    a_on: assert property (p_on) else $error("comparator on wrong");
    property p_pin; wr_cfg |-> ##2 result_pin_en == (wm_r inside {3'h1, 3'h3, 3'h5}); endproperty
    a_pin: assert property (p_pin) else $error("result pin enable wrong");
    property p_ana;
        wr_cfg |-> ##2 analog_pin_en == (wm_r inside {3'h3, 3'h4} ? 2'h2 : wm_r == 3'h7 ? 2'h0 : 2'h3);
    endproperty
    a_ana: assert property (p_ana) else $error("analog pins wrong");
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err; psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h014); endproperty
    a_err: assert property (p_err) else $error("pslverr wrong");
    property p_follow;
        $changed(cmp_raw) && ce && $past(ce) && comparator_on && !wr_cfg && !$past(wr_cfg)
        |=> $changed(result_pin_out);
    endproperty
    a_follow: assert property (p_follow) else $error("result did not follow");
    property p_wake; $rose(wake_req) |-> core_sleep && $past(core_sleep); endproperty
    a_wake: assert property (p_wake) else $error("wake outside sleep");
    property p_isr; isr_req |-> $past(instr_done); endproperty
    a_isr: assert property (p_isr) else $error("branch before next instruction");
    property p_pulse; isr_req |=> !isr_req; endproperty
    a_pulse: assert property (p_pulse) else $error("branch request too long");
    c_wake: cover property ($rose(wake_req));
    c_isr: cover property (isr_req);
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule

// ==== bench/core_model.sv ====
// Behavioural core: sleeps on request, wakes on wake_req, retires one instruction
`timescale 1ns/100ps
module core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go_sleep,
    input  wire logic [3:0] lag,
    input  wire logic       wake_req,
    output logic            core_sleep,
    output logic            instr_done
);
    logic [3:0] wait_r;
    logic       step_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_sleep <= 1'b0;
            instr_done <= 1'b0;
            wait_r     <= 4'h0;
            step_r     <= 1'b0;
        end else begin
            instr_done <= step_r;
            step_r     <= 1'b0;
            if (go_sleep) begin
                core_sleep <= 1'b1;
            end else if (core_sleep && wake_req) begin
                // Lag models a slow oscillator start-up
                wait_r <= wait_r + 4'h1;
                if (wait_r == lag) begin
                    core_sleep <= 1'b0;
                    step_r     <= 1'b1;
                    wait_r     <= 4'h0;
                end
            end
        end
    end
endmodule

// ==== bench/cmp_ctrl_tb.sv ====
// Self-checking bench for the comparator control block
`timescale 1ns/100ps
module cmp_ctrl_tb;
    logic        pclk, presetn, psel, penable, pwrite, cmp_raw, go_sleep, e, ce;
    logic        pready, pslverr, core_sleep, instr_done, comparator_on, input_switch;
    logic        result_pin_out, result_pin_en, irq, wake_req, isr_req;
    logic [1:0]  analog_pin_en, aux_ctrl;
    logic [3:0]  lag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          err_total, compares;

    cmp_ctrl cmp_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .core_sleep(core_sleep),
        .instr_done(instr_done), .comparator_on(comparator_on), .analog_pin_en(analog_pin_en),
        .input_switch(input_switch), .result_pin_out(result_pin_out),
        .result_pin_en(result_pin_en), .aux_ctrl(aux_ctrl), .irq(irq), .wake_req(wake_req),
        .isr_req(isr_req));
    core_model core_model_i (.pclk(pclk), .presetn(presetn), .go_sleep(go_sleep), .lag(lag),
        .wake_req(wake_req), .core_sleep(core_sleep), .instr_done(instr_done));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t bus answer timed out", $time);
            end_sim();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge pclk);
    endtask

    task automatic raw(input logic v);
        @(posedge pclk);
        cmp_raw <= v;
    endtask

    task automatic nap();
        @(posedge pclk);
        go_sleep <= 1'b1;
        @(posedge pclk);
        go_sleep <= 1'b0;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (instr_done !== 1'b1 && n < 64);
        if (instr_done !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t core wake timed out", $time);
            end_sim();
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, cmp_raw, go_sleep} = 6'h0;
        ce = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        lag = 4'h0;
        err_total = 0;
        compares = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0);
        xfer(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0);
        chk({28'h0, comparator_on, result_pin_en, analog_pin_en}, 32'h0000_0003);
        // Clock enable low: the write is answered but must not land
        ce <= 1'b0;
        xfer(1'b1, 12'h000, 32'h0000_0001);
        cyc(3);
        chk({31'h0, comparator_on}, 32'h0);
        @(posedge pclk);
        ce <= 1'b1;
        $display("reset test done");
        for (int m = 0; m < 8; m++) begin
            xfer(1'b1, 12'h000, 32'(m));
            cyc(3);
            chk({31'h0, comparator_on}, {31'h0, m != 0 && m != 7});
            chk({31'h0, result_pin_en}, {31'h0, m inside {1, 3, 5}});
        end
        // Off mode with invert set reads one
        xfer(1'b1, 12'h000, 32'hFFFF_FFFF);
        cyc(3);
        xfer(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0000_005F);
        chk({31'h0, input_switch}, 32'h1);
        xfer(1'b1, 12'h004, 32'hFFFF_FFFF);
        xfer(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0000_0003);
        chk({30'h0, aux_ctrl}, 32'h0000_0003);
        // Reset in mid-run must bring both control registers back
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0);
        chk({30'h0, aux_ctrl}, 32'h0);
        $display("mode test done");
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 12'h000, {27'h0, i[1], 4'h1});
            raw(i[0]);
            cyc(3);
            chk({31'h0, result_pin_out}, {31'h0, i[1] ^ i[0]});
            xfer(1'b0, 12'h000, 32'h0);
            chk(q & 32'h0000_0040, {25'h0, i[1] ^ i[0], 6'h0});
        end
        $display("invert test done");
        xfer(1'b1, 12'h010, 32'h0);
        xfer(1'b1, 12'h00C, 32'h3);
        xfer(1'b0, 12'h008, 32'h0);
        chk(q, 32'h0);
        raw(1'b0);
        cyc(4);
        // Mismatch still standing, so the clear is refused
        xfer(1'b1, 12'h00C, 32'h1);
        xfer(1'b0, 12'h008, 32'h0);
        chk({q[30:0], irq}, 32'h2);
        xfer(1'b1, 12'h010, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b0, 12'h000, 32'h0);
        xfer(1'b1, 12'h00C, 32'h1);
        xfer(1'b0, 12'h008, 32'h0);
        chk({q[30:0], irq}, 32'h0);
        xfer(1'b0, 12'h020, 32'h0);
        chk({q[30:0], e}, 32'h1);
        $display("flag test done");
        xfer(1'b1, 12'h014, 32'h0);
        nap();
        raw(1'b1);
        cyc(12);
        chk({29'h0, wake_req, core_sleep, result_pin_out}, 32'h2);
        lag <= 4'h5;
        xfer(1'b1, 12'h014, 32'h1);
        wait_done();
        cyc(1);
        chk({31'h0, isr_req}, 32'h0);
        xfer(1'b1, 12'h014, 32'h3);
        lag <= 4'h0;
        nap();
        wait_done();
        cyc(1);
        chk({31'h0, isr_req}, 32'h1);
        xfer(1'b0, 12'h008, 32'h0);
        chk(q, 32'h0000_0003);
        // No wake wanted: switch off and clear flags before sleeping
        xfer(1'b1, 12'h000, 32'h0);
        xfer(1'b1, 12'h00C, 32'h3);
        nap();
        cyc(8);
        chk({27'h0, wake_req, core_sleep, comparator_on, analog_pin_en}, 32'h0000_000B);
        $display("sleep test done");
        end_sim();
    end
endmodule

bind cmp_ctrl cmp_ctrl_properties props_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
    .core_sleep(core_sleep), .instr_done(instr_done), .comparator_on(comparator_on),
    .analog_pin_en(analog_pin_en), .input_switch(input_switch),
    .result_pin_out(result_pin_out), .result_pin_en(result_pin_en), .aux_ctrl(aux_ctrl),
    .irq(irq), .wake_req(wake_req), .isr_req(isr_req));
